// >>> verilog/ssync_top.sv
/*
 * switching clock select and sync: strap decode, internal oscillator,
 * external clock detect and lock, loss shut-off, register port.
 * assumes the sync pin is resolved outside from sync_out/sync_oe and
 * its level arrives on sync_clk; strap and enable inputs are async.
 */
// Summary of operation
// - mode strap picks sync pin role
// - output mode drives 400 kHz oscillator out
// - output mode ignores incoming sync clock
// - input mode checks clock each enable
// - lock oscillator to external rising edges
// - clock loss turns both switches off
// - auto mode checks clock after enable
// - auto, no clock: strap sets frequency
// - strap resistor selects tabulated frequency
// - straps sampled once after power-up
// - programmed frequency is 8 MHz / N
// - reported period is quantized
`timescale 1ns/1ps
`default_nettype none
module ssync_top (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        sync_clk,
   output logic             sync_out,
   output logic             sync_oe,
   input  wire logic        en,
   input  wire logic [1:0]  cfg_level,
   input  wire logic [1:0]  sync_level,
   input  wire logic        res_valid,
   input  wire logic [4:0]  res_code,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [31:0]      rd_data,
   output logic             high_side_switch,
   output logic             low_side_switch
);
   // =====================================================================
   // link domain: edge toggle on the sync pin clock
   logic lk_rst_meta;
   logic lk_rst;
   logic lk_tog;

   always_ff @(posedge sync_clk) begin
      lk_rst_meta <= reset;
      lk_rst      <= lk_rst_meta;
      if (lk_rst) begin
         lk_tog <= 1'b0;
      end else begin
         lk_tog <= ~lk_tog;
      end
   end

   // =====================================================================
   // system domain state
   ssync_pkg::ssync_state_s s;
   ssync_pkg::ssync_state_s n;

   // state names, local so the package is never imported
   localparam ssync_pkg::ssync_st_e st_boot   = ssync_pkg::st_boot;
   localparam ssync_pkg::ssync_st_e st_ready  = ssync_pkg::st_ready;
   localparam ssync_pkg::ssync_st_e st_detect = ssync_pkg::st_detect;
   localparam ssync_pkg::ssync_st_e st_run    = ssync_pkg::st_run;

   function automatic logic [9:0] per_of(input logic [5:0] nv);
      logic [10:0] p;
      p = 11'(nv) * 11'(ssync_pkg::PER_NUM);
      return p[10:1];
   endfunction

   function automatic logic [5:0] strap_n_of(
      input logic [1:0] lvl, input logic rv, input logic [4:0] rc);
      logic [4:0] i;
      i = (rc > ssync_pkg::RES_LAST) ? ssync_pkg::RES_LAST : rc;
      if (rv) begin
         return ssync_pkg::RES_N[i];
      end
      case (lvl)
         ssync_pkg::LVL_LOW:  return ssync_pkg::N_LOW;
         ssync_pkg::LVL_HIGH: return ssync_pkg::N_HIGH;
         default:             return ssync_pkg::N_OPEN;
      endcase
   endfunction

   logic        ext_edge;
   logic        en_s;
   logic        en_rise;
   logic [5:0]  int_n;
   logic [9:0]  int_per;
   logic [9:0]  half;
   logic        out_mode;

   always_comb begin
      n        = s;
      n.meta   = {res_code, res_valid, sync_level, cfg_level, en, lk_tog};
      n.sy     = s.meta;
      n.tg_d   = s.sy[0];
      n.en_d   = s.sy[1];
      ext_edge = s.sy[0] ^ s.tg_d;
      en_s     = s.sy[1];
      en_rise  = en_s & ~s.en_d;
      out_mode = (s.mode == ssync_pkg::LVL_HIGH);
      if (s.prog_en) begin
         int_n = s.prog_n;
      end else if (out_mode) begin
         int_n = ssync_pkg::N_OUT_DEF;
      end else begin
         int_n = s.strap_n;
      end
      int_per = per_of(int_n);

      // internal oscillator free-runs unless locked to the link
      if (s.st == st_run && s.locked) begin
         n.gap = s.gap + 10'h001;
         if (ext_edge) begin
            n.cnt     = 10'h000;
            n.ext_per = s.cnt + 10'h001;
            n.gap     = 10'h000;
         end else begin
            n.cnt = s.cnt + 10'h001;
         end
      end else if (s.cnt >= int_per - 10'h001) begin
         n.cnt = 10'h000;
      end else begin
         n.cnt = s.cnt + 10'h001;
      end

      case (s.st)
         st_boot: begin
            n.boot_cnt = s.boot_cnt + 5'h01;
            if (s.boot_cnt == ssync_pkg::BOOT_CYC - 5'h01) begin
               n.mode    = s.sy[3:2];
               n.strap_n = strap_n_of(s.sy[5:4], s.sy[6],
                                      s.sy[11:7]);
               n.st      = st_ready;
            end
         end
         st_ready: begin
            if (en_rise) begin
               n.lost   = 1'b0;
               n.nolock = 1'b0;
               n.locked = 1'b0;
               if (out_mode) begin
                  n.st = st_run;
               end else begin
                  n.st    = st_detect;
                  n.win   = 12'h000;
                  n.gap   = 10'h000;
                  n.edges = 3'h0;
               end
            end
         end
         st_detect: begin
            n.win = s.win + 12'h001;
            n.gap = s.gap + 10'h001;
            if (ext_edge) begin
               n.gap   = 10'h000;
               n.edges = s.edges + 3'h1;
            end else if (s.gap >= ssync_pkg::LOSS_CYC - 10'h001) begin
               n.edges = 3'h0;
            end
            if (ext_edge && s.edges == ssync_pkg::DET_EDGES - 3'h1) begin
               n.st     = st_run;
               n.locked = 1'b1;
               n.cnt    = 10'h000;
               n.ext_per = int_per;
            end else if (s.win >= ssync_pkg::DET_CYC - 12'h001) begin
               // window sized for the slowest legal clock
               if (s.mode == ssync_pkg::LVL_OPEN) begin
                  n.st = st_run;
               end else begin
                  n.st     = st_ready;
                  n.nolock = 1'b1;
               end
            end
         end
         st_run: begin
            if (s.locked && !ext_edge &&
                s.gap >= ssync_pkg::LOSS_CYC - 10'h001) begin
               n.st     = st_ready;
               n.lost   = 1'b1;
               n.locked = 1'b0;
            end
         end
         default: begin
            n.st = st_boot;
         end
      endcase
      if (s.st != st_boot && !en_s) begin
         n.st     = st_ready;
         n.locked = 1'b0;
      end

      half = n.locked ? (n.ext_per >> 1) : (int_per >> 1);
      n.hs = (n.st == st_run) && (n.cnt < half);
      n.ls = (n.st == st_run) && !(n.cnt < half);
      n.soe = (n.st != st_boot) && (n.mode == ssync_pkg::LVL_HIGH);
      n.so  = n.soe && (n.cnt < (int_per >> 1));

      // register port
      if (wr_en && addr == ssync_pkg::ADDR_CTRL) begin
         if (wr_data[5:0] >= ssync_pkg::N_MIN &&
             wr_data[5:0] <= ssync_pkg::N_MAX) begin
            n.prog_n  = wr_data[5:0];
            n.prog_en = wr_data[ssync_pkg::CTRL_EN_BIT];
         end
      end
      n.rdata = 32'h0000_0000;
      if (rd_en) begin
         case (addr)
            ssync_pkg::ADDR_CTRL: begin
               n.rdata = {23'h000000, s.prog_en, 2'h0, s.prog_n};
            end
            ssync_pkg::ADDR_STAT: begin
               // period in system cycles, as quantized
               n.rdata = {6'h00, (s.locked ? s.ext_per : int_per),
                          2'h0, int_n, 1'b0, s.nolock, s.lost,
                          s.locked, s.mode, s.st};
            end
            default: begin
               n.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s         <= '0;
         s.st      <= st_boot;
         s.mode    <= ssync_pkg::LVL_OPEN;
         s.strap_n <= ssync_pkg::N_OPEN;
         s.prog_n  <= ssync_pkg::PROG_N_RST;
      end else begin
         s <= n;
      end
   end

   assign high_side_switch = s.hs;
   assign low_side_switch  = s.ls;
   assign sync_out         = s.so;
   assign sync_oe          = s.soe;
   assign rd_data          = s.rdata;

   // =====================================================================
   // checks
   default clocking ck @(posedge sys_clk); endclocking
   default disable iff (reset);

   mode_strap_a: assert property (
      (s.st == st_boot && n.st == st_ready) |=> s.mode == $past(s.sy[3:2]))
      else $error("mode not taken from strap");
   out_drive_a: assert property (
      (s.st == st_ready && out_mode) |=> sync_oe)
      else $error("sync pin not driven in output mode");
   out_nodet_a: assert property (
      (s.st != st_boot && out_mode) |-> (s.st != st_detect && !s.locked))
      else $error("clock detect active in output mode");
   en_check_a: assert property (
      (s.st == st_ready && en_rise && !out_mode) |=> s.st == st_detect)
      else $error("no clock check on enable");
   lock_edge_a: assert property (
      (s.st == st_run && s.locked && ext_edge && en_s) |=> s.cnt == 10'h000)
      else $error("phase not reset on external edge");
   loss_off_a: assert property (
      (s.st == st_run && s.locked && !ext_edge &&
       s.gap >= ssync_pkg::LOSS_CYC - 10'h001)
      |=> (!high_side_switch && !low_side_switch && s.lost))
      else $error("switches on after clock loss");
   auto_fall_a: assert property (
      (s.st == st_detect && en_s && s.mode == ssync_pkg::LVL_OPEN &&
       !ext_edge && s.win == ssync_pkg::DET_CYC - 12'h001)
      |=> (s.st == st_run && !s.locked))
      else $error("auto mode did not fall back to strap");
   strap_hold_a: assert property (
      (s.st != st_boot) |=> ($stable(s.strap_n) && $stable(s.mode)))
      else $error("strap setting changed after start-up");
   prog_range_a: assert property (
      (s.prog_n >= ssync_pkg::N_MIN && s.prog_n <= ssync_pkg::N_MAX))
      else $error("programmed divider out of range");
   lock_count_a: assert property (
      $rose(s.locked) |-> $past(s.edges) == ssync_pkg::DET_EDGES - 3'h1)
      else $error("locked without enough edges");
   no_overlap_a: assert property (
      !(high_side_switch && low_side_switch))
      else $error("both switches on");

   // =====================================================================
   // checks: strap decode, detect outcome, register port, loss flag, enable off
   res_strap_a: assert property (
      (s.st == st_boot && n.st == st_ready && s.sy[6] &&
       s.sy[11:7] <= ssync_pkg::RES_LAST)
      |=> s.strap_n == ssync_pkg::RES_N[$past(s.sy[11:7])])
      else $error("resistor strap not decoded");
   lvl_strap_a: assert property (
      (s.st == st_boot && n.st == st_ready && !s.sy[6] &&
       s.sy[5:4] == ssync_pkg::LVL_LOW)
      |=> s.strap_n == ssync_pkg::N_LOW)
      else $error("low level strap not decoded");
   in_nolock_a: assert property (
      (s.st == st_detect && en_s && s.mode == ssync_pkg::LVL_LOW &&
       !ext_edge && s.win == ssync_pkg::DET_CYC - 12'h001)
      |=> (s.st == st_ready && s.nolock && !high_side_switch))
      else $error("input mode ran without a clock");
   auto_lock_a: assert property (
      (s.st == st_detect && en_s && s.mode == ssync_pkg::LVL_OPEN &&
       ext_edge && s.edges == ssync_pkg::DET_EDGES - 3'h1)
      |=> (s.st == st_run && s.locked))
      else $error("auto mode did not lock to clock");
   prog_take_a: assert property (
      (wr_en && addr == ssync_pkg::ADDR_CTRL &&
       wr_data[5:0] >= ssync_pkg::N_MIN &&
       wr_data[5:0] <= ssync_pkg::N_MAX)
      |=> (s.prog_n == $past(wr_data[5:0])))
      else $error("programmed divider not taken");
   prog_keep_a: assert property (
      (wr_en && addr == ssync_pkg::ADDR_CTRL &&
       (wr_data[5:0] < ssync_pkg::N_MIN ||
        wr_data[5:0] > ssync_pkg::N_MAX))
      |=> ($stable(s.prog_n) && $stable(s.prog_en)))
      else $error("out of range divider was taken");
   stat_per_a: assert property (
      (rd_en && addr == ssync_pkg::ADDR_STAT && !s.locked)
      |=> rd_data[25:16] == 10'((11'($past(int_n)) * 11'h019) >> 1))
      else $error("reported period not quantized");
   loss_hold_a: assert property (
      (s.st == st_ready && s.lost && !en_rise) |=> s.lost)
      else $error("clock loss flag dropped");
   en_off_a: assert property (
      (s.st != st_boot && !en_s)
      |=> (!high_side_switch && !low_side_switch))
      else $error("switches on while enable low");

   lock_c: cover property ($rose(s.locked));
   lost_c: cover property ($rose(s.lost));
   fall_c: cover property (s.st == st_detect ##1 s.st == st_run && !s.locked);
   out_run_c: cover property (out_mode && s.st == st_run);
   nolock_c: cover property ($rose(s.nolock));
endmodule
`default_nettype wire

// >>> verilog/ssync_pkg.sv
/*
 * constants and types of the switching clock select and sync block.
 * assumes a 100 MHz system clock and a strap sensor that reports each
 * three-level pin as a two-bit level code.
 */
`default_nettype none
package ssync_pkg;
   // =====================================================================
   // timing
   localparam int SYS_CLK_KHZ  = 100000;
   localparam int BASE_CLK_KHZ = 8000;
   // cycles per base period, doubled so it stays integer
   localparam int PER_NUM      = 2 * SYS_CLK_KHZ / BASE_CLK_KHZ;
   localparam int LOSS_TIME_US = 10;
   localparam logic [9:0] LOSS_CYC =
      10'(LOSS_TIME_US * SYS_CLK_KHZ / 1000);
   localparam int DET_TIME_US  = 30;
   localparam logic [11:0] DET_CYC =
      12'(DET_TIME_US * SYS_CLK_KHZ / 1000);
   localparam logic [2:0] DET_EDGES = 3'h4;
   localparam logic [4:0] BOOT_CYC  = 5'h10;
   // =====================================================================
   // divider values
   localparam logic [5:0] N_MIN     = 6'h04;
   localparam logic [5:0] N_MAX     = 6'h28;
   localparam logic [5:0] N_LOW     = 6'h28;
   localparam logic [5:0] N_OPEN    = 6'h14;
   localparam logic [5:0] N_HIGH    = 6'h08;
   localparam logic [5:0] N_OUT_DEF = 6'h14;
   localparam logic [4:0] RES_LAST  = 5'h14;
   localparam logic [5:0] RES_N [0:20] = '{
      6'h28, 6'h24, 6'h21, 6'h1E, 6'h1B, 6'h19, 6'h16,
      6'h14, 6'h13, 6'h11, 6'h0F, 6'h0E, 6'h0D, 6'h0C,
      6'h0B, 6'h09, 6'h08, 6'h07, 6'h06, 6'h05, 6'h04};
   // =====================================================================
   // strap level codes
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_OPEN = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   // =====================================================================
   // registers
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam int         CTRL_EN_BIT = 8;
   localparam logic [5:0] PROG_N_RST  = 6'h14;
   // =====================================================================
   // types
   typedef enum logic [1:0] {
      st_boot, st_ready, st_detect, st_run
   } ssync_st_e;
   typedef struct packed {
      ssync_st_e   st;
      logic [11:0] meta;
      logic [11:0] sy;
      logic        tg_d;
      logic        en_d;
      logic [4:0]  boot_cnt;
      logic [1:0]  mode;
      logic [5:0]  strap_n;
      logic [5:0]  prog_n;
      logic        prog_en;
      logic        locked;
      logic        lost;
      logic        nolock;
      logic [9:0]  cnt;
      logic [9:0]  ext_per;
      logic [9:0]  gap;
      logic [11:0] win;
      logic [2:0]  edges;
      logic        hs;
      logic        ls;
      logic        so;
      logic        soe;
      logic [31:0] rdata;
   } ssync_state_s;
endpackage
`default_nettype wire

// >>> tb/ssync_clk_source.sv
/*
 * external sync clock source of the switching clock bench.
 * assumes the bench resolves the shared pin and sets run before enable.
 */
`timescale 1ns/1ps
`default_nettype none
module ssync_clk_source (
   input  wire logic run,
   output logic      src_clk
);
   // =====================================================================
   // free clock, stands still at its last level while run is low
   initial begin
      src_clk = 1'b0;
      #37;
      forever begin
         #80;
         if (run) begin
            src_clk = ~src_clk;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/ssync_bench.sv
/*
 * self-checking bench of the switching clock select and sync block.
 * assumes ssync_pkg, ssync_top and ssync_clk_source compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module ssync_bench;
   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] exp;
   } ssync_note_s;
   logic        sys_clk, reset, en, run, res_valid, wr_en, rd_en, rd_d, rv;
   logic        sync_clk, sync_out, sync_oe, src_clk, hs, ls;
   logic [1:0]  cfg_level, sync_level, lvl;
   logic [4:0]  res_code, rc;
   logic [5:0]  nexp;
   logic [7:0]  addr, lf;
   logic [31:0] wr_data, rd_data;
   int          mismatches, checks, n;
   ssync_note_s q[$];
   localparam logic [5:0] LVL_N [0:2] = '{6'h28, 6'h14, 6'h08};

   assign sync_clk = sync_oe ? sync_out : src_clk;

   ssync_top ssync_top_i (.sys_clk(sys_clk), .reset(reset),
      .sync_clk(sync_clk), .sync_out(sync_out), .sync_oe(sync_oe),
      .en(en), .cfg_level(cfg_level), .sync_level(sync_level),
      .res_valid(res_valid), .res_code(res_code), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .high_side_switch(hs), .low_side_switch(ls));
   ssync_clk_source ssync_clk_source_i (.run(run), .src_clk(src_clk));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // =====================================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      @(posedge sys_clk);
      q.push_back({m, e});
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
   endtask
   task automatic boot(input logic [1:0] c, input logic [1:0] s,
                       input logic v, input logic [4:0] r);
      @(posedge sys_clk);
      reset <= 1'b1;
      en <= 1'b0;
      run <= 1'b1;
      cfg_level <= c;
      sync_level <= s;
      res_valid <= v;
      res_code <= r;
      tick(50);
      check({28'h0, hs, ls, sync_oe, sync_out}, 32'h0, "outputs in reset");
      reset <= 1'b0;
      tick(25);
   endtask
   task automatic enable(input int k);
      @(posedge sys_clk);
      en <= 1'b0;
      tick(5);
      en <= 1'b1;
      tick(k);
   endtask
   // cycles between two rising edges of the sync output or high side
   task automatic per(input logic sel, output int p);
      int c;
      p = 0;
      c = 0;
      repeat (2) begin
         while ((sel ? hs : sync_out) !== 1'b0 && c < 2000) begin
            @(posedge sys_clk);
            c++;
         end
         while ((sel ? hs : sync_out) !== 1'b1 && c < 2000) begin
            @(posedge sys_clk);
            c++;
         end
         p = c - p;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // =====================================================================
   // read monitor and watchdog
   always @(posedge sys_clk) begin
      if (rd_d) begin
         check(rd_data & q[0].mask, q[0].exp, "register read");
         void'(q.pop_front());
      end
      rd_d <= rd_en;
   end
   initial begin
      repeat (80000) @(posedge sys_clk);
      mismatches++;
      $display("MISMATCH %0t watchdog expired", $time);
      close_out;
   end

   // =====================================================================
   // tests
   initial begin
      reset = 1'b1;
      en = 1'b0;
      run = 1'b1;
      cfg_level = 2'h0;
      sync_level = 2'h0;
      res_valid = 1'b0;
      res_code = 5'h00;
      addr = 8'h00;
      wr_data = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      rd_d = 1'b0;
      mismatches = 0;
      checks = 0;
      lf = 8'h20;
      boot(ssync_pkg::LVL_HIGH, ssync_pkg::LVL_OPEN, 1'b0, 5'h00);
      rd(ssync_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000014);
      wr(8'h08, 32'h0000010A);
      rd(8'h08, 32'hFFFFFFFF, 32'h00000000);
      wr(ssync_pkg::ADDR_CTRL, 32'h00000103);
      wr(ssync_pkg::ADDR_CTRL, 32'h00000129);
      rd(ssync_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000014);
      enable(300);
      rd(ssync_pkg::ADDR_STAT, 32'h03FF3F7F, 32'h00FA140B);
      check({31'h0, sync_oe}, 32'h1, "pin not driven");
      per(1'b0, n);
      check(n, 32'd250, "default period");
      for (int i = 0; i < 2; i++) begin
         wr(ssync_pkg::ADDR_CTRL, (i == 1) ? 32'h00000128 : 32'h00000104);
         per(1'b0, n);
         per(1'b0, n);
         check(n, (i == 1) ? 32'd500 : 32'd50, "programmed period");
      end
      rd(ssync_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000128);
      $display("output mode test done");
      boot(ssync_pkg::LVL_LOW, ssync_pkg::LVL_OPEN, 1'b0, 5'h00);
      run <= 1'b0;
      enable(3100);
      rd(ssync_pkg::ADDR_STAT, 32'h7F, 32'h41);
      check({30'h0, hs, ls}, 32'h0, "switching without clock");
      run <= 1'b1;
      tick(40);
      enable(300);
      rd(ssync_pkg::ADDR_STAT, 32'h7F, 32'h13);
      per(1'b1, n);
      check(n, 32'd16, "locked switching period");
      run <= 1'b0;
      tick(1015);
      check({30'h0, hs, ls}, 32'h0, "switching after loss");
      rd(ssync_pkg::ADDR_STAT, 32'h2F, 32'h21);
      $display("input mode test done");
      for (int i = 0; i < 5; i++) begin
         lf = lfsr(lf);
         lvl = (i < 3) ? 2'(i) : ssync_pkg::LVL_OPEN;
         rv = (i >= 3);
         rc = (i == 3) ? 5'h14 : 5'(lf % 21);
         nexp = rv ? ssync_pkg::RES_N[rc] : LVL_N[lvl];
         boot(ssync_pkg::LVL_OPEN, lvl, rv, rc);
         run <= 1'b0;
         repeat (2) begin
            enable(3100);
            rd(ssync_pkg::ADDR_STAT, 32'h03FF3F7F, {6'h0,
               10'((32'(nexp) * 25) / 2), 2'h0, nexp, 8'h07});
            sync_level <= 2'((lvl + 2'h1) % 3);
            res_valid <= ~rv;
         end
      end
      boot(ssync_pkg::LVL_OPEN, ssync_pkg::LVL_OPEN, 1'b0, 5'h00);
      enable(300);
      rd(ssync_pkg::ADDR_STAT, 32'h7F, 32'h17);
      tick(3);
      $display("auto mode test done");
      close_out;
   end
endmodule
`default_nettype wire
